/* File: dchp_pkg.sv */
// constants and types shared by the dual channel host port design
// assumes a single 20 MHz clock and a synchronous active-low reset
package dchp_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_BPS = 115_200;
    // whole cycles per serial bit, rounded down
    localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
    // infrared pulse is three sixteenths of a bit
    localparam int IR_CYC = (BIT_CYC * 3) / 16;
    localparam int CNT_W = 8;

    // register indices selected by reg_sel
    localparam logic [2:0] REG_TXHOLD = 3'h0;
    localparam logic [2:0] REG_IRQEN = 3'h1;
    localparam logic [2:0] REG_STAT_AUX = 3'h2;
    localparam logic [2:0] REG_MODEM = 3'h4;
    localparam logic [2:0] REG_LINE = 3'h5;
    localparam logic [2:0] REG_SCRATCH = 3'h7;

    // field positions
    localparam int IRQEN_TX_BIT = 1;
    localparam int MODEM_IR_BIT = 6;
    localparam int AUX_BCAST_BIT = 0;
    localparam int LINE_THRE_BIT = 5;
    localparam int LINE_TEMT_BIT = 6;

    // read values and reset values
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [7:0] ISR_TXE = 8'h02;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // channel indices
    localparam int CH_A = 0;
    localparam int CH_B = 1;

    // synchroniser bundle {cs_n, pick, rd_n, wr_n, sel[2:0], data[7:0]}
    localparam int SYNC_W = 15;
    localparam logic [SYNC_W-1:0] SYNC_RST = 15'h7800;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_RD = 3'b010,
        BUS_WR = 3'b100
    } dchp_bus_type;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } dchp_txst_type;

endpackage

/* File: dchp_tx_if.sv */
// link between the register logic and one serial transmitter
// assumes both ends share one clock
`timescale 1ns/10ps
interface dchp_tx_if;
    logic load;
    logic [7:0] data;
    logic infrared;
    logic busy;
    logic line;
    modport ctl(output load, output data, output infrared, input busy, input line);
    modport ser(input load, input data, input infrared, output busy, output line);
endinterface

/* File: dchp_sync.sv */
// two flip-flop synchroniser for the asynchronous host pins
// assumes the pins are quiet long enough around strobe edges
`timescale 1ns/10ps
module dchp_sync
    import dchp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [SYNC_W-1:0] pins,
    output logic [SYNC_W-1:0] pins_sync
);
    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
    } dchp_sync_type;

    dchp_sync_type s_r;
    dchp_sync_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = pins;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '{meta: SYNC_RST, stable: SYNC_RST};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign pins_sync = s_r.stable;
endmodule

/* File: dchp_tx.sv */
// serial transmitter, 8 data bits, one stop bit, with infrared encoding
// assumes load is only raised while busy is low
`timescale 1ns/10ps
module dchp_tx
    import dchp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    dchp_tx_if.ser txi
);
    typedef struct packed {
        dchp_txst_type st;
        logic [CNT_W-1:0] cnt;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic line;
    } dchp_tx_type;

    dchp_tx_type s_r;
    dchp_tx_type s_nxt;

    function automatic logic encode(input logic b, input logic [CNT_W-1:0] c, input logic ir);
        // infrared sends a short high pulse for a zero and stays low otherwise
        encode = ir ? (!b && (c < CNT_W'(IR_CYC))) : b;
    endfunction

    always_comb begin
        logic b;
        logic last;
        b = 1'b1;
        last = (s_r.cnt == CNT_W'(BIT_CYC - 1));
        s_nxt = s_r;
        if (s_r.st != TX_IDLE) begin
            s_nxt.cnt = last ? '0 : s_r.cnt + 1'b1;
        end
        unique case (s_r.st)
            TX_IDLE: begin
                b = 1'b1;
                if (txi.load) begin
                    s_nxt.sh = txi.data;
                    s_nxt.cnt = '0;
                    s_nxt.st = TX_START;
                end
            end
            TX_START: begin
                b = 1'b0;
                if (last) begin
                    s_nxt.st = TX_DATA;
                    s_nxt.bitn = 3'h0;
                end
            end
            TX_DATA: begin
                b = s_r.sh[0];
                if (last) begin
                    s_nxt.sh = {1'b0, s_r.sh[7:1]};
                    s_nxt.bitn = s_r.bitn + 1'b1;
                    if (s_r.bitn == 3'h7) begin
                        s_nxt.st = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                b = 1'b1;
                if (last) begin
                    s_nxt.st = TX_IDLE;
                end
            end
        endcase
        s_nxt.line = encode(b, s_r.cnt, txi.infrared);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // standard mode is the reset mode, so the line rests high
            s_r <= '{st: TX_IDLE, cnt: '0, bitn: 3'h0, sh: BYTE_RST, line: 1'b1};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign txi.busy = (s_r.st != TX_IDLE);
    assign txi.line = s_r.line;
endmodule

/* File: dchp_host_port.sv */
// host bus port of a two channel serial device
// assumes asynchronous strobes, each held low at least four clock cycles
// Notes on behaviour
// - read strobe fall fetches selected register byte
// - write strobe rise stores data byte
// - transfers happen only with chip select low
// - channel_pick low means B, high A
// - broadcast bit writes both channels at once
// - irq_chan_a high while channel A needs service
// - irq_chan_b high while channel B needs service
// - tx_space_a_n shows channel A holding state
// - tx_space_b_n shows channel B holding state
// - standard mode line idles high, also in reset
// - infrared bit selects infrared encoding
// - infrared line rests low when idle
// - reg_sel picks one register of channel
// - host_data bidirectional, device drives on reads
`timescale 1ns/10ps
module dchp_host_port
    import dchp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic chip_select_n,
    input wire logic channel_pick,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic irq_chan_a,
    output logic irq_chan_b,
    output logic tx_space_a_n,
    output logic tx_space_b_n,
    output logic serial_out_a,
    output logic serial_out_b
);
    typedef struct packed {
        dchp_bus_type st;
        logic rd_prev_n;
        logic wr_prev_n;
        logic [7:0] dout;
        logic [7:0] aux;
        logic [1:0][7:0] tx_holding_reg;
        logic [1:0] thr_full;
        logic [1:0][7:0] ier;
        logic [1:0][7:0] modem_ctl_reg;
        logic [1:0][7:0] scr;
        logic [1:0] load;
    } dchp_port_type;

    localparam dchp_port_type PORT_RST = '{
        st: BUS_IDLE, rd_prev_n: 1'b1, wr_prev_n: 1'b1, dout: BYTE_RST,
        aux: BYTE_RST, tx_holding_reg: {BYTE_RST, BYTE_RST}, thr_full: 2'b00,
        ier: {BYTE_RST, BYTE_RST}, modem_ctl_reg: {BYTE_RST, BYTE_RST},
        scr: {BYTE_RST, BYTE_RST}, load: 2'b00};

    dchp_port_type s_r;
    dchp_port_type s_nxt;

    logic [SYNC_W-1:0] pins_sync;
    logic cs_n_s;
    logic pick_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [2:0] sel_s;
    logic [7:0] data_s;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    logic [7:0] rd_val;
    logic [1:0] tx_busy;
    logic [1:0] tx_line;

    dchp_tx_if tx_a();
    dchp_tx_if tx_b();

    dchp_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .pins({chip_select_n, channel_pick, read_strobe_n, write_strobe_n, reg_sel,
            host_data_in}),
        .pins_sync(pins_sync)
    );

    dchp_tx u_tx_a (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .txi(tx_a.ser)
    );

    dchp_tx u_tx_b (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .txi(tx_b.ser)
    );

    assign {cs_n_s, pick_s, rd_n_s, wr_n_s, sel_s, data_s} = pins_sync;
    // edges come from synced copies, so a strobe shorter than one cycle may be lost
    assign rd_fall = s_r.rd_prev_n && !rd_n_s;
    assign wr_fall = s_r.wr_prev_n && !wr_n_s;
    assign wr_rise = !s_r.wr_prev_n && wr_n_s;

    function automatic int chan_of(input logic pick);
        chan_of = pick ? CH_A : CH_B;
    endfunction

    function automatic logic [7:0] read_reg(input dchp_port_type s, input int ch,
            input logic [2:0] sel, input logic busy);
        logic [7:0] v;
        v = BYTE_RST;
        unique case (sel)
            REG_IRQEN: v = s.ier[ch];
            REG_STAT_AUX: v = (s.ier[ch][IRQEN_TX_BIT] && !s.thr_full[ch]) ? ISR_TXE : ISR_NONE;
            REG_MODEM: v = s.modem_ctl_reg[ch];
            REG_LINE: begin
                v[LINE_THRE_BIT] = !s.thr_full[ch];
                v[LINE_TEMT_BIT] = !s.thr_full[ch] && !busy;
            end
            REG_SCRATCH: v = s.scr[ch];
            // no receiver here, so the data register reads as zero
            default: v = BYTE_RST;
        endcase
        read_reg = v;
    endfunction

    assign tx_busy = {tx_b.busy, tx_a.busy};
    assign tx_line = {tx_b.line, tx_a.line};
    assign rd_val = read_reg(s_r, chan_of(pick_s), sel_s, tx_busy[chan_of(pick_s)]);

    always_comb begin
        logic [1:0] hit;
        hit = 2'b00;
        s_nxt = s_r;
        s_nxt.rd_prev_n = rd_n_s;
        s_nxt.wr_prev_n = wr_n_s;
        // holding register feeds an idle transmitter; load is a one-cycle pulse
        for (int c = 0; c < 2; c++) begin
            s_nxt.load[c] = s_r.thr_full[c] && !tx_busy[c] && !s_r.load[c];
            if (s_nxt.load[c]) begin
                s_nxt.thr_full[c] = 1'b0;
            end
        end
        unique case (s_r.st)
            BUS_IDLE: begin
                if (rd_fall && !cs_n_s) begin
                    s_nxt.dout = rd_val;
                    s_nxt.st = BUS_RD;
                end else if (wr_fall && !cs_n_s) begin
                    s_nxt.st = BUS_WR;
                end
            end
            BUS_RD: begin
                if (rd_n_s) begin
                    s_nxt.st = BUS_IDLE;
                end
            end
            BUS_WR: begin
                if (wr_n_s) begin
                    s_nxt.st = BUS_IDLE;
                end
            end
        endcase
        if (s_r.st == BUS_WR && wr_rise && !cs_n_s) begin
            if (s_r.aux[AUX_BCAST_BIT]) begin
                hit = 2'b11;
            end else begin
                hit[chan_of(pick_s)] = 1'b1;
            end
            if (sel_s == REG_STAT_AUX) begin
                s_nxt.aux = data_s;
            end
            for (int c = 0; c < 2; c++) begin
                if (hit[c]) begin
                    unique case (sel_s)
                        REG_TXHOLD: begin
                            // a new byte wins over the transfer in the same cycle
                            s_nxt.tx_holding_reg[c] = data_s;
                            s_nxt.thr_full[c] = 1'b1;
                        end
                        REG_IRQEN: s_nxt.ier[c] = data_s;
                        REG_MODEM: s_nxt.modem_ctl_reg[c] = data_s;
                        REG_SCRATCH: s_nxt.scr[c] = data_s;
                        default: s_nxt.scr[c] = s_r.scr[c];
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= PORT_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tx_a.load = s_r.load[CH_A];
    assign tx_a.data = s_r.tx_holding_reg[CH_A];
    assign tx_a.infrared = s_r.modem_ctl_reg[CH_A][MODEM_IR_BIT];
    assign tx_b.load = s_r.load[CH_B];
    assign tx_b.data = s_r.tx_holding_reg[CH_B];
    assign tx_b.infrared = s_r.modem_ctl_reg[CH_B][MODEM_IR_BIT];

    // drive only during a selected read so the host bus never sees contention
    assign host_data_oe = (s_r.st == BUS_RD) && !cs_n_s && !rd_n_s;
    assign host_data_out = s_r.dout;
    assign irq_chan_a = s_r.ier[CH_A][IRQEN_TX_BIT] && !s_r.thr_full[CH_A];
    assign irq_chan_b = s_r.ier[CH_B][IRQEN_TX_BIT] && !s_r.thr_full[CH_B];
    // ready pins follow the holding flag only; there is no transmit fifo behind it
    assign tx_space_a_n = s_r.thr_full[CH_A];
    assign tx_space_b_n = s_r.thr_full[CH_B];
    assign serial_out_a = tx_line[CH_A];
    assign serial_out_b = tx_line[CH_B];

    default clocking dchp_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b || !ce);

    a_read_fetch: assert property (rd_fall && !cs_n_s && s_r.st == BUS_IDLE ##1 ce
        |-> s_r.st == BUS_RD && s_r.dout == $past(rd_val))
        else $error("read did not fetch the selected byte");
    a_oe_release: assert property (host_data_oe |-> !cs_n_s && !rd_n_s)
        else $error("data bus driven outside a selected read");
    a_oe_follows: assert property (rd_fall && !cs_n_s && s_r.st == BUS_IDLE
        ##1 (!rd_n_s && !cs_n_s) |-> host_data_oe)
        else $error("data bus not driven during read");
    a_write_lands: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_SCRATCH && !s_r.aux[AUX_BCAST_BIT]
        |=> s_r.scr[chan_of($past(pick_s))] == $past(data_s))
        else $error("write byte not stored");
    a_pick_route: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_SCRATCH && !s_r.aux[AUX_BCAST_BIT] && !pick_s
        |=> $stable(s_r.scr[CH_A]))
        else $error("low pick reached channel A");
    a_bcast_both: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_MODEM && s_r.aux[AUX_BCAST_BIT]
        |=> s_r.modem_ctl_reg[CH_A] == $past(data_s) && s_r.modem_ctl_reg[CH_B] == $past(data_s))
        else $error("broadcast write missed a channel");
    a_no_cs_write: assert property (cs_n_s |=> $stable(s_r.scr) && $stable(s_r.modem_ctl_reg))
        else $error("write took effect without chip select");
    a_irq_a: assert property (s_r.ier[CH_A][IRQEN_TX_BIT] && !tx_space_a_n
        |-> irq_chan_a)
        else $error("channel A service request missing");
    a_irq_b: assert property (irq_chan_b |-> !tx_space_b_n)
        else $error("channel B request without holding space");
    a_space_a: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_TXHOLD && (pick_s || s_r.aux[AUX_BCAST_BIT]) |=> tx_space_a_n)
        else $error("channel A holding state not shown");
    a_space_b: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_TXHOLD && (!pick_s || s_r.aux[AUX_BCAST_BIT]) |=> tx_space_b_n)
        else $error("channel B holding state not shown");
    a_reset_high: assert property (@(posedge clk) disable iff (1'b0)
        !rst_b |=> serial_out_a)
        else $error("line not high after reset");
    a_ir_idle: assert property ((tx_a.infrared && !tx_a.busy)[*2]
        |-> !serial_out_a)
        else $error("infrared line not resting low");
    a_std_idle: assert property ((!tx_a.infrared && !tx_a.busy)[*2]
        |-> serial_out_a)
        else $error("standard line not resting high");
    a_no_cs_start: assert property (cs_n_s && s_r.st == BUS_IDLE
        |=> s_r.st == BUS_IDLE)
        else $error("transfer started without chip select");
    a_pick_high: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_SCRATCH && !s_r.aux[AUX_BCAST_BIT] && pick_s
        |=> $stable(s_r.scr[CH_B]))
        else $error("high pick reached channel B");
    a_aux_write: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_STAT_AUX |=> s_r.aux == $past(data_s))
        else $error("function register write lost");

    // a full holding register withdraws the request and shows busy on the ready pin
    a_irq_a_full: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_TXHOLD && (pick_s || s_r.aux[AUX_BCAST_BIT]) |=> !irq_chan_a)
        else $error("channel A request while holding register full");
    a_irq_b_full: assert property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && sel_s == REG_TXHOLD && (!pick_s || s_r.aux[AUX_BCAST_BIT]) |=> !irq_chan_b)
        else $error("channel B request while holding register full");
    a_space_a_free: assert property (tx_space_a_n && !tx_a.busy && !tx_a.load
        && s_r.st != BUS_WR |=> !tx_space_a_n)
        else $error("channel A holding space not freed");
    a_space_b_free: assert property (tx_space_b_n && !tx_b.busy && !tx_b.load
        && s_r.st != BUS_WR |=> !tx_space_b_n)
        else $error("channel B holding space not freed");
    // the transmitter drops a load that arrives while it is busy
    a_load_idle: assert property (tx_a.load |-> !tx_a.busy)
        else $error("channel A load while transmitter busy");

    c_read: cover property (rd_fall && !cs_n_s ##[1:20] host_data_oe);
    c_write_a: cover property (s_r.st == BUS_WR && wr_rise && !cs_n_s && pick_s);
    c_bcast: cover property (s_r.st == BUS_WR && wr_rise && !cs_n_s
        && s_r.aux[AUX_BCAST_BIT]);
    c_ir_send: cover property (tx_a.infrared && tx_a.load);
    c_write_b: cover property (s_r.st == BUS_WR && wr_rise && !cs_n_s && !pick_s);
endmodule

/* File: dchp_host_model.sv */
// host processor model on the asynchronous byte bus of the host port
// assumes the caller starts each task just after a rising clock edge
`timescale 1ns/10ps
module dchp_host_model (
    input wire logic clk,
    output logic chip_select_n,
    output logic channel_pick,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [2:0] reg_sel,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe
);
    logic drv_r;
    logic [7:0] val_r;

    // a bus nobody drives shows the inverse of its last level, not a kind default
    assign host_data_in = host_data_oe ? host_data_out : (drv_r ? val_r : ~val_r);

    initial begin
        chip_select_n = 1'b1;
        channel_pick = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        reg_sel = 3'h0;
        drv_r = 1'b0;
        val_r = 8'h00;
    end

    task automatic setup(input logic en, input logic ch, input logic [2:0] sel);
        @(posedge clk);
        chip_select_n <= ~en;
        channel_pick <= ch;
        reg_sel <= sel;
    endtask

    task automatic wr(input logic en, input logic ch, input logic [2:0] sel, input logic [7:0] d);
        setup(en, ch, sel);
        val_r <= d;
        drv_r <= 1'b1;
        @(posedge clk);
        write_strobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        write_strobe_n <= 1'b1;
        // data and select held past the rise, strobe high long enough
        repeat (4) @(posedge clk);
        chip_select_n <= 1'b1;
        drv_r <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic rd(input logic en, input logic ch, input logic [2:0] sel,
            output logic [7:0] d, output logic oe);
        setup(en, ch, sel);
        @(posedge clk);
        read_strobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        d = host_data_in;
        oe = host_data_oe;
        read_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        chip_select_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* File: dchp_host_port_tb.sv */
// self-checking bench for the dual channel host port
// assumes the host model above and the design's package constants
`timescale 1ns/10ps
module dchp_host_port_tb;
    import dchp_pkg::*;

    logic clk;
    logic rst_b;
    logic ce;
    logic chip_select_n;
    logic channel_pick;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [2:0] reg_sel;
    logic [7:0] host_data_in;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic irq_chan_a;
    logic irq_chan_b;
    logic tx_space_a_n;
    logic tx_space_b_n;
    logic serial_out_a;
    logic serial_out_b;
    int mismatches = 0;
    int compares = 0;
    int busy_cnt = 0;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] g;
    logic oe;
    int pulses;
    int hi;

    dchp_host_port u_dchp_host_port (.clk(clk), .rst_b(rst_b), .ce(ce),
        .chip_select_n(chip_select_n), .channel_pick(channel_pick),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .reg_sel(reg_sel), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .irq_chan_a(irq_chan_a), .irq_chan_b(irq_chan_b),
        .tx_space_a_n(tx_space_a_n), .tx_space_b_n(tx_space_b_n),
        .serial_out_a(serial_out_a), .serial_out_b(serial_out_b));

    dchp_host_model u_dchp_host_model (.clk(clk), .chip_select_n(chip_select_n),
        .channel_pick(channel_pick), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .reg_sel(reg_sel), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // pick high is channel A, so index by pick
    function automatic logic line(input logic p);
        return p ? serial_out_a : serial_out_b;
    endfunction

    function automatic int ir_zeros(input logic [7:0] v);
        return 9 - $countones(v);
    endfunction

    always @(posedge clk) begin
        if ((channel_pick ? tx_space_a_n : tx_space_b_n) === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    task automatic rx_frame(input logic p, output logic [7:0] b);
        int n;
        n = 0;
        b = 8'h00;
        while (line(p) !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        cmp1(line(p), 1'b0, "start bit");
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = line(p);
        end
        repeat (BIT_CYC) @(posedge clk);
        cmp1(line(p), 1'b1, "stop bit");
    endtask

    task automatic ir_count(output int np, output int nh);
        logic prev;
        prev = 1'b0;
        np = 0;
        nh = 0;
        repeat (11 * BIT_CYC) begin
            @(posedge clk);
            np += (serial_out_a && !prev) ? 1 : 0;
            nh += serial_out_a ? 1 : 0;
            prev = serial_out_a;
        end
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        give_verdict;
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        void'($urandom(50));
        repeat (5) @(posedge clk);
        cmp1(serial_out_a, 1'b1, "reset line");
        cmp1(host_data_oe, 1'b0, "reset oe");
        cmp1(tx_space_a_n, 1'b0, "reset space");
        cmp1(irq_chan_a | irq_chan_b, 1'b0, "reset irq");
        rst_b <= 1'b1;
        u_dchp_host_model.rd(1'b1, 1'b1, REG_MODEM, g, oe);
        cmp8(g, BYTE_RST, "modem reset");
        u_dchp_host_model.rd(1'b1, 1'b1, REG_LINE, g, oe);
        cmp8(g, 8'(1 << LINE_THRE_BIT) | 8'(1 << LINE_TEMT_BIT), "line status");
        $display("test reset done");

        for (int k = 0; k < 6; k++) begin
            d = 8'($urandom());
            e = (k == 0) ? ~d : 8'($urandom());
            u_dchp_host_model.wr(1'b1, 1'b1, REG_SCRATCH, d);
            u_dchp_host_model.wr(1'b1, 1'b0, REG_SCRATCH, e);
            u_dchp_host_model.wr(1'b0, 1'b1, REG_SCRATCH, ~d);
            u_dchp_host_model.rd(1'b1, 1'b1, REG_SCRATCH, g, oe);
            cmp8(g, d, "scratch A");
            cmp1(oe, 1'b1, "read drive");
            u_dchp_host_model.rd(1'b1, 1'b0, REG_SCRATCH, g, oe);
            cmp8(g, e, "scratch B");
        end
        // a write made while the clock enable is low must leave no trace
        ce <= 1'b0;
        u_dchp_host_model.wr(1'b1, 1'b1, REG_SCRATCH, ~d);
        ce <= 1'b1;
        u_dchp_host_model.rd(1'b1, 1'b1, REG_SCRATCH, g, oe);
        cmp8(g, d, "frozen write");
        u_dchp_host_model.rd(1'b0, 1'b1, REG_SCRATCH, g, oe);
        cmp1(oe, 1'b0, "unselected read");
        $display("test scratch done");

        d = 8'($urandom());
        u_dchp_host_model.wr(1'b1, 1'b1, REG_STAT_AUX, 8'h01);
        u_dchp_host_model.wr(1'b1, 1'b1, REG_SCRATCH, d);
        // infrared stays off so the later serial test sees standard lines
        e = d & ~8'(1 << MODEM_IR_BIT);
        u_dchp_host_model.wr(1'b1, 1'b1, REG_MODEM, e);
        u_dchp_host_model.wr(1'b1, 1'b1, REG_STAT_AUX, 8'h00);
        u_dchp_host_model.wr(1'b1, 1'b1, REG_SCRATCH, ~d);
        u_dchp_host_model.rd(1'b1, 1'b0, REG_SCRATCH, g, oe);
        cmp8(g, d, "broadcast B");
        u_dchp_host_model.rd(1'b1, 1'b0, REG_MODEM, g, oe);
        cmp8(g, e, "broadcast modem B");
        $display("test broadcast done");

        for (int p = 1; p >= 0; p--) begin
            u_dchp_host_model.wr(1'b1, 1'(p), REG_IRQEN, 8'h02);
            cmp1(irq_chan_a, 1'(p), "irq a");
            cmp1(irq_chan_b, 1'(!p), "irq b");
            u_dchp_host_model.rd(1'b1, 1'(p), REG_STAT_AUX, g, oe);
            cmp8(g, ISR_TXE, "status pending");
            u_dchp_host_model.wr(1'b1, 1'(p), REG_IRQEN, 8'h00);
            cmp1(irq_chan_a | irq_chan_b, 1'b0, "irq off");
        end
        $display("test irq done");

        for (int p = 1; p >= 0; p--) begin
            d = (p == 1) ? 8'h80 : 8'($urandom());
            cmp1(line(1'(p)), 1'b1, "idle high");
            busy_cnt = 0;
            fork
                u_dchp_host_model.wr(1'b1, 1'(p), REG_TXHOLD, d);
                rx_frame(1'(p), g);
            join
            cmp8(g, d, "serial byte");
            cmp1(busy_cnt > 0, 1'b1, "space busy");
            cmp1(p ? tx_space_a_n : tx_space_b_n, 1'b0, "space free");
        end
        $display("test serial done");

        u_dchp_host_model.wr(1'b1, 1'b1, REG_MODEM, 8'h40);
        cmp1(serial_out_a, 1'b0, "ir idle");
        d = 8'($urandom());
        fork
            u_dchp_host_model.wr(1'b1, 1'b1, REG_TXHOLD, d);
            ir_count(pulses, hi);
        join
        cmp1(pulses == ir_zeros(d), 1'b1, "ir pulses");
        cmp1(hi == ir_zeros(d) * IR_CYC, 1'b1, "ir width");
        cmp1(serial_out_a, 1'b0, "ir rest");
        $display("test infrared done");
        give_verdict;
    end
endmodule
